/* hw/mcp_pkg.sv */
// Purpose: Shared constants and carriers for the motion command frame parser
// Assumes: Byte-wide links, one command in flight at a time
// Notes: Status codes and frame lengths live here only
package mcp_pkg;
  localparam logic [3:0] FRAME_LEN_SERIAL = 4'h9;
  localparam logic [3:0] FRAME_LEN_CAN = 4'h7;
  localparam logic [3:0] BODY_LEN = 4'h7;
  localparam logic [3:0] REPLY_LEN_SERIAL = 4'h9;
  localparam logic [3:0] REPLY_LEN_CAN = 4'h7;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
  localparam logic [7:0] MODULE_ADDR_RST = 8'h01;
  localparam logic [7:0] REPLY_ADDR_RST = 8'h02;

  typedef struct packed {
    logic [7:0] cmdNum;
    logic [7:0] cmdType;
    logic [7:0] bank;
    logic [31:0] value;
  } mcp_cmd_s;

  typedef struct packed {
    logic [2:0] err;
    logic stored;
    logic [31:0] value;
  } mcp_result_s;

  typedef enum logic [3:0] {
    ST_RX = 4'h1,
    ST_EXEC = 4'h2,
    ST_WAIT = 4'h4,
    ST_TX = 4'h8
  } mcp_state_e;

  function automatic logic [7:0] mcp_add8(input logic [7:0] a, input logic [7:0] b);
    mcp_add8 = a + b;
  endfunction : mcp_add8
endpackage : mcp_pkg

/* hw/mcp_reply_ser.sv */
// Purpose: Serialises one reply frame, byte by byte, with running checksum
// Assumes: Load only while idle
// Notes: Byte order fixed; value goes out MSB first
`timescale 1ns/10ps
module mcp_reply_ser
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Load side
  input wire logic load,
  input wire logic canMode,
  input wire logic [63:0] frame,
  // Byte stream
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic busy
);
  logic [63:0] shift_q;
  logic [3:0] left_q;
  logic [7:0] sum_q;
  logic [7:0] data_q;
  logic valid_q;
  logic sendSum_q;
  wire logic take = valid_q && txReady;
  wire logic [7:0] nextByte = shift_q[63:56];
  wire logic moreBody = left_q != 4'h0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_q <= 64'h0;
      left_q <= 4'h0;
      sum_q <= 8'h00;
      data_q <= 8'h00;
      valid_q <= 1'b0;
      sendSum_q <= 1'b0;
    end else if (load && !valid_q) begin
      shift_q <= canMode ? {frame[47:0], 16'h0000} : {frame[55:0], 8'h00};
      data_q <= canMode ? frame[55:48] : frame[63:56];
      sum_q <= canMode ? 8'h00 : frame[63:56];
      left_q <= canMode ? (REPLY_LEN_CAN - 4'h1) : (REPLY_LEN_SERIAL - 4'h2);
      sendSum_q <= !canMode;
      valid_q <= 1'b1;
    end else if (take) begin
      if (moreBody) begin
        data_q <= nextByte;
        sum_q <= mcp_add8(sum_q, nextByte);
        shift_q <= {shift_q[55:0], 8'h00};
        left_q <= left_q - 4'h1;
      end else if (sendSum_q) begin
        data_q <= sum_q;
        sendSum_q <= 1'b0;
      end else begin
        valid_q <= 1'b0;
      end
    end
  end

  assign txData = data_q;
  assign txValid = valid_q;
  assign busy = valid_q;
endmodule : mcp_reply_ser

/* hw/mcp_frame_parser.sv */
// Purpose: Receives command frames, checks them, hands them on, returns replies
// Assumes: Executor answers each issued command with one done pulse
// Notes: No receive buffer; bytes during execution or reply are dropped
`timescale 1ns/10ps
module mcp_frame_parser
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic canMode,
  input wire logic [7:0] moduleAddr,
  input wire logic [7:0] replyAddr,
  // Received bytes
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxFrameStart,
  // Executor side
  output mcp_cmd_s cmdOut,
  output logic cmdValid,
  input wire logic execDone,
  input wire mcp_result_s execResult,
  // Reply bytes
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic txActive,
  output logic [7:0] txCanId
);
  mcp_state_e state_q, state_d;
  logic [3:0] idx_q;
  logic [7:0] sum_q;
  logic addrOk_q;
  mcp_cmd_s cmd_q;
  logic cmdValid_q;
  logic [7:0] status_q;
  logic [31:0] replyVal_q;
  logic load_q;
  logic txActive_q;
  logic [7:0] canId_q;
  logic serBusy;
  logic [7:0] serData;
  logic serValid;

  // A start marker restarts the count, so a cut frame cannot shift the next one
  wire logic [3:0] curIdx = rxFrameStart ? 4'h0 : idx_q;
  wire logic [3:0] lastIdx = (canMode ? FRAME_LEN_CAN : FRAME_LEN_SERIAL) - 4'h1;
  // Byte position in the body, CAN has no address byte
  wire logic [3:0] bodyIdx = canMode ? curIdx : (curIdx - 4'h1);
  wire logic rxTake = rxValid && (state_q == ST_RX);
  wire logic isLast = rxTake && (curIdx == lastIdx);
  wire logic addrTake = rxTake && (curIdx == 4'h0);
  wire logic inBody = !canMode ? (curIdx != 4'h0) && (curIdx != lastIdx) : 1'b1;
  wire logic bodyTake = rxTake && inBody;
  wire logic [3:0] idxNext = isLast ? 4'h0 : (curIdx + 4'h1);
  wire logic [7:0] sumNext = (curIdx == 4'h0) ? rxData : mcp_add8(sum_q, rxData);

  // Frame verdict at the last byte
  wire logic sumOk = canMode || (rxData == sum_q);
  wire logic frameFor = canMode || addrOk_q;
  wire logic frameEnd = isLast && frameFor;
  wire logic sumFail = frameEnd && !sumOk;
  wire logic resultIn = (state_q == ST_WAIT) && execDone;

  // Error code outranks the stored flag
  function automatic logic [7:0] statusOf(input mcp_result_s r);
    logic [7:0] code;
    code = r.stored ? ST_STORED : ST_OK;
    if (r.err != 3'h0) begin
      code = {5'h00, r.err};
    end
    statusOf = code;
  endfunction : statusOf

  // Reply contents
  wire logic [7:0] execStatus = statusOf(execResult);
  wire logic replyDone = (state_q == ST_TX) && !load_q && !serBusy;
  wire logic [63:0] replyFrame = {replyAddr, moduleAddr, status_q, cmd_q.cmdNum, replyVal_q};
  wire logic loadClr = load_q && serBusy;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RX: begin
        if (isLast && frameFor) begin
          state_d = sumOk ? ST_EXEC : ST_TX;
        end
      end
      ST_EXEC: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (execDone) begin
          state_d = ST_TX;
        end
      end
      ST_TX: begin
        if (replyDone) begin
          state_d = ST_RX;
        end
      end
      default: begin
        state_d = ST_RX;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_RX;
    end else begin
      state_q <= state_d;
    end
  end

  // Receive position and running sum
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (rxTake) begin
      idx_q <= idxNext;
      sum_q <= sumNext;
    end
  end

  // Match dropped at frame end so it cannot leak into the next frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addrOk_q <= 1'b0;
    end else if (isLast) begin
      addrOk_q <= 1'b0;
    end else if (addrTake) begin
      addrOk_q <= rxData == moduleAddr;
    end
  end

  // Command body capture, value shifted in MSB first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q <= '0;
    end else if (bodyTake) begin
      if (bodyIdx == 4'h0) begin
        cmd_q.cmdNum <= rxData;
      end else if (bodyIdx == 4'h1) begin
        cmd_q.cmdType <= rxData;
      end else if (bodyIdx == 4'h2) begin
        cmd_q.bank <= rxData;
      end else begin
        cmd_q.value <= {cmd_q.value[23:0], rxData};
      end
    end
  end

  // One-cycle issue pulse, two cycles after the last byte, while in ST_WAIT
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmdValid_q <= 1'b0;
    end else begin
      cmdValid_q <= state_q == ST_EXEC;
    end
  end

  // Reply status and value, from a checksum failure or the executor
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= 8'h00;
      replyVal_q <= 32'h0;
    end else if (sumFail) begin
      status_q <= ST_BAD_SUM;
      replyVal_q <= 32'h0;
    end else if (resultIn) begin
      status_q <= execStatus;
      replyVal_q <= execResult.value;
    end
  end

  // Held until the serializer takes it; a new load wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_q <= 1'b0;
    end else if (sumFail || resultIn) begin
      load_q <= 1'b1;
    end else if (loadClr) begin
      load_q <= 1'b0;
    end
  end

  // Reply window and CAN identifier
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txActive_q <= 1'b0;
      canId_q <= 8'h00;
    end else begin
      txActive_q <= (state_q == ST_TX);
      canId_q <= replyAddr;
    end
  end

  mcp_reply_ser u_ser (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(load_q),
    .canMode(canMode),
    .frame(replyFrame),
    .txData(serData),
    .txValid(serValid),
    .txReady(txReady),
    .busy(serBusy)
  );

  assign cmdOut = cmd_q;
  assign cmdValid = cmdValid_q;
  assign txData = serData;
  assign txValid = serValid;
  assign txActive = txActive_q;
  assign txCanId = canId_q;
endmodule : mcp_frame_parser

/* test/mcp_parser_asserts.sv */
// Purpose: Port checks for the frame parser
// Assumes: Executor answers one or more cycles after issue
// Notes: Reply byte values are judged by the bench
`timescale 1ns/10ps
module mcp_parser_chk
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Config
  input wire logic canMode,
  input wire logic [7:0] replyAddr,
  // Executor side
  input wire mcp_cmd_s cmdOut,
  input wire logic cmdValid,
  // Reply side
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic txActive,
  input wire logic [7:0] txCanId
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_one_pulse; cmdValid |=> !cmdValid; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("issue too long");
  property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_in_reply; txValid |-> txActive; endproperty
  a_in_reply: assert property (p_in_reply) else $error("send outside reply");
  property p_issue_idle; cmdValid |-> !txActive; endproperty
  a_issue_idle: assert property (p_issue_idle) else $error("issue in reply");
  property p_no_early; cmdValid |=> !txActive [*2]; endproperty
  a_no_early: assert property (p_no_early) else $error("reply before done");
  property p_cmd_keep; txActive && $past(txActive) |-> $stable(cmdOut); endproperty
  a_cmd_keep: assert property (p_cmd_keep) else $error("command moved");
  property p_can_id; canMode && !$past(rst) |-> txCanId == $past(replyAddr); endproperty
  a_can_id: assert property (p_can_id) else $error("bad identifier");
  property p_fall_hs; $fell(txValid) |-> $past(txReady); endproperty
  a_fall_hs: assert property (p_fall_hs) else $error("byte dropped");
  cover property (cmdValid);
  cover property (txValid && !txReady);
  cover property (canMode && txValid);
endmodule : mcp_parser_chk

bind mcp_frame_parser mcp_parser_chk i_chk (.*);

/* test/mcp_host_model.sv */
// Purpose: Host model sending frames and gathering replies
// Assumes: One frame in flight
// Notes: Slow mode drops ready every other cycle
`timescale 1ns/10ps
module mcp_host_model (
  // Clock
  input wire logic clk_sys,
  // Command bytes
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFrameStart,
  // Reply bytes
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic [7:0] got[$];
  bit slow, odd;
  initial begin
    {rxData, rxValid, rxFrameStart} = '0;
  end
  always @(posedge clk_sys) begin
    if (txValid && txReady) got.push_back(txData);
    odd <= !odd;
    txReady <= #1 !slow || odd;
  end
  // Bytes go out from the top of f
  task automatic send(input logic [71:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) #1;
      rxData = f[71-8*i -: 8];
      rxValid = 1'b1;
      rxFrameStart = (i == 0);
    end
    @(posedge clk_sys) #1;
    {rxValid, rxFrameStart} = '0;
    rxData = ~rxData;
  endtask : send
endmodule : mcp_host_model

/* test/tb_top.sv */
// Purpose: Frame parser bench
// Assumes: Host model on the byte side
// Notes: Executor is played here
`timescale 1ns/10ps
module tb_top;
  import mcp_pkg::*;
  logic clk_sys, rst, canMode, cmdValid, execDone, txValid, txReady, txActive, rxValid, rxFrameStart;
  logic [7:0] moduleAddr, replyAddr, rxData, txData, txCanId;
  mcp_cmd_s cmdOut;
  mcp_result_s execResult;
  int mismatches = 0;
  int cmp_count = 0;
  mcp_frame_parser i_dut (.*);
  mcp_host_model i_host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // One frame, executor reply, whole reply compared
  task automatic xact(input logic [7:0] a, input logic [55:0] b, input bit bad, input mcp_result_s r, input bit go);
    logic [7:0] s, st, e[$];
    int k;
    s = a;
    for (k = 0; k < 7; k++) s += b[55-8*k -: 8];
    i_host.got.delete();
    i_host.send(canMode ? {b, 16'h0000} : {a, b, s ^ {7'h00, bad}}, canMode ? 7 : 9);
    for (k = 0; k < 12 && cmdValid !== 1'b1; k++) @(posedge clk_sys) #1;
    chk(k < 12, go);
    if (go) begin
      chk(cmdOut, b);
      repeat (3) @(posedge clk_sys) #1;
      execResult = r;
      execDone = 1'b1;
      @(posedge clk_sys) #1;
      execDone = 1'b0;
      execResult = ~r;
    end
    st = bad ? ST_BAD_SUM : r.err != 0 ? {5'h00, r.err} : r.stored ? ST_STORED : ST_OK;
    if (!canMode) e.push_back(replyAddr);
    e = {e, moduleAddr, st, b[55:48], r.value[31:24], r.value[23:16], r.value[15:8], r.value[7:0]};
    s = 8'h00;
    foreach (e[i]) s += e[i];
    if (!canMode) e.push_back(s);
    if (!go && !bad) e.delete();
    // Next frame only after the reply is in
    for (k = 0; k < 80 && i_host.got.size() < e.size(); k++) @(posedge clk_sys) #1;
    if (k == 80) begin
      $display("BAD %0t timeout %h %h", $time, i_host.got.size(), e.size());
      mismatches++;
      wrap_up();
    end
    repeat (4) @(posedge clk_sys) #1;
    chk(i_host.got.size(), e.size());
    foreach (e[i]) chk(i_host.got[i], e[i]);
  endtask : xact
  task automatic t_ok;
    i_host.slow = 1'b1;
    xact(moduleAddr, 56'hF1E2D389ABCDEF, 0, {4'h0, 32'h8081FEFF}, 1);
    i_host.slow = 1'b0;
  endtask : t_ok
  task automatic t_stored;
    // Cut frame first: the next start marker must resynchronise
    i_host.send({moduleAddr, 64'h0}, 8);
    xact(moduleAddr, 56'h05010000000010, 0, {4'h1, 32'h00000000}, 1);
  endtask : t_stored
  task automatic t_errs;
    for (int n = 1; n < 7; n++) xact(moduleAddr, 56'h0F020000000001, 0, {n[2:0], 33'h0}, 1);
  endtask : t_errs
  task automatic t_bad;
    xact(moduleAddr, 56'h06FF0180000000, 1, '0, 0);
    xact(~moduleAddr, 56'h01000000000005, 0, '0, 0);
  endtask : t_bad
  task automatic t_can;
    canMode = 1'b1;
    @(posedge clk_sys) #1;
    chk(txCanId, replyAddr);
    xact(moduleAddr, 56'h06040000012345, 0, {4'h0, 32'h00012345}, 1);
    canMode = 1'b0;
  endtask : t_can
  initial begin
    {rst, canMode, execDone} = 3'b100;
    execResult = '0;
    moduleAddr = 8'h05;
    replyAddr = 8'h02;
    repeat (10) @(posedge clk_sys) #1;
    rst = 1'b0;
    t_ok();
    t_stored();
    t_errs();
    t_bad();
    t_can();
    wrap_up();
  end
endmodule : tb_top
